// ---- design/msd_statistics.sv ----
// Summary of operation
// - Min/max tracking restarts on its clear event, on device reset and on any config write.
// - A dedicated clear source resets all minimum values together, apart from the maxima.
// - A separate clear source resets all maximum values together, apart from the minima.
// - Min/max clears act only on a rising edge, never repeatedly on a steady high.
// - Current, voltage and power averages are three groups with their own settings.
// - Current and power groups keep peaks that clear together with their averages.
// - A sliding window averages over a period that moves forward with every sample.
// - A fixed window starts afresh at the end of each period.
// - Duration start mode takes the period length from the group duration setting.
// - Edge start mode with a fixed window averages between two consecutive rising edges of the start pin; a sliding window uses the last edge-to-edge length.
// - A direct command clears one group's average and peak at once.
// - A rising edge on a group's enabled clear pin clears that group.
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "msd_cfg.svh"
module msd_statistics #(
  parameter int DEPTH = 64
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output logic                    pready,
  output var  logic               pslverr,
  input  wire msd_pkg::msd_meas_t meas,
  input  wire logic               current_avg_start_source,
  input  wire logic               voltage_avg_start_source,
  input  wire logic               power_avg_start_source,
  input  wire logic               current_avg_clear_source,
  input  wire logic               voltage_avg_clear_source,
  input  wire logic               power_avg_clear_source,
  input  wire logic               minimum_clear_source,
  input  wire logic               maximum_clear_source
);
  import msd_pkg::*;

  localparam int NPIN = 8;

  // Pin synchronisers: bits 0..2 start, 3..5 group clear, 6 min clear, 7 max clear
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_lvl;

  wire [NPIN-1:0]  pins = {maximum_clear_source, minimum_clear_source,
                           power_avg_clear_source, voltage_avg_clear_source,
                           current_avg_clear_source, power_avg_start_source,
                           voltage_avg_start_source, current_avg_start_source};
  // A level is accepted only when the second and third stages agree
  wire [NPIN-1:0]  next_pin_lvl = (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
  wire [NPIN-1:0]  pin_rise = next_pin_lvl & ~pin_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1  <= '0;
      pin_s2  <= '0;
      pin_s3  <= '0;
      pin_lvl <= '0;
    end else begin
      pin_s1  <= pins;
      pin_s2  <= pin_s1;
      pin_s3  <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end

  // Register state
  logic [31:0]     ctrl;
  logic [15:0]     dur [3];
  msd_value_t      min_q [3];
  msd_value_t      max_q [3];
  logic [2:0]      min_seen;
  logic [2:0]      max_seen;
  msd_value_t      avg_q [3];
  msd_value_t      peak_q [3];

  // APB decode
  wire [1:0]       lane     = paddr[3:2];
  wire             lane_ok  = lane != 2'd3;
  wire [11:0]      blk      = paddr & `MSD_BLOCK_MASK;
  wire             a_ctrl   = {paddr[11:2], 2'b00} == `MSD_OFF_CTRL;
  wire             a_cmd    = {paddr[11:2], 2'b00} == `MSD_OFF_CMD;
  wire             a_status = {paddr[11:2], 2'b00} == `MSD_OFF_STATUS;
  wire             in_dur   = (blk == `MSD_OFF_DUR) && lane_ok;
  wire             in_avg   = (blk == `MSD_OFF_AVG) && lane_ok;
  wire             in_peak  = (blk == `MSD_OFF_PEAK) && ((lane == 2'd0) || (lane == 2'd2));
  wire             in_min   = (blk == `MSD_OFF_MIN) && lane_ok;
  wire             in_max   = (blk == `MSD_OFF_MAX) && lane_ok;
  wire             hit      = a_ctrl | a_cmd | a_status | in_dur | in_avg | in_peak |
                              in_min | in_max;
  wire             setup    = psel & ~penable;
  wire             wr       = psel & penable & pwrite;
  wire             wr_ctrl  = wr & a_ctrl;
  wire             wr_dur   = wr & in_dur;
  wire             wr_cmd   = wr & a_cmd;
  wire             cfg_write = wr_ctrl | wr_dur;

  wire [1:0]       rl       = lane_ok ? lane : 2'd0;
  wire [31:0]      status   = {18'h0, max_seen, min_seen, pin_lvl};
  wire [31:0]      rdata    = a_ctrl   ? ctrl :
                              a_status ? status :
                              in_dur   ? {16'h0, dur[rl]} :
                              in_avg   ? {16'h0, avg_q[rl]} :
                              in_peak  ? {16'h0, peak_q[rl]} :
                              in_min   ? {16'h0, min_q[rl]} :
                              in_max   ? {16'h0, max_q[rl]} : 32'h0000_0000;

  assign pready = 1'b1;

  // Read data is captured in the setup phase so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= (hit && !pwrite) ? rdata : 32'h0000_0000;
      pslverr <= !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `MSD_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= pwdata & `MSD_CTRL_MASK;
    end
  end

  // Min/max clear events
  wire min_clr = cfg_write |
                 (wr_cmd & pwdata[`MSD_CMD_MIN_CLR]) |
                 (ctrl[`MSD_CTRL_MINCLR_EN] & pin_rise[6]);
  wire max_clr = cfg_write |
                 (wr_cmd & pwdata[`MSD_CMD_MAX_CLR]) |
                 (ctrl[`MSD_CTRL_MAXCLR_EN] & pin_rise[7]);

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : grp
      localparam int CB = `MSD_CTRL_GRP_STRIDE * g;

      msd_grp_cfg_t gcfg;
      assign gcfg.win   = msd_win_t'(ctrl[CB + `MSD_CTRL_WIN]);
      assign gcfg.start = msd_start_t'(ctrl[CB + `MSD_CTRL_START]);
      assign gcfg.dur   = dur[g];

      wire wr_this_dur = wr_dur & (lane == 2'(g));
      // Any config write restarts the group so stale history never mixes in
      wire gclr = cfg_write |
                  (wr_cmd & pwdata[`MSD_CMD_GRP_CLR + g]) |
                  (ctrl[CB + `MSD_CTRL_CLREN] & pin_rise[3 + g]);

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dur[g] <= `MSD_DUR_RST;
        end else if (wr_this_dur) begin
          dur[g] <= pwdata[15:0];
        end
      end

      wire msd_value_t x = meas.val[g];
      wire take_min = meas.valid && (!min_seen[g] || (x < min_q[g]));
      wire take_max = meas.valid && (!max_seen[g] || (x > max_q[g]));

      // A clear and a sample in the same cycle: the clear wins, next sample restarts
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          min_q[g]    <= `MSD_MIN_RST;
          min_seen[g] <= 1'b0;
        end else if (min_clr) begin
          min_q[g]    <= `MSD_MIN_RST;
          min_seen[g] <= 1'b0;
        end else if (take_min) begin
          min_q[g]    <= x;
          min_seen[g] <= 1'b1;
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          max_q[g]    <= `MSD_MAX_RST;
          max_seen[g] <= 1'b0;
        end else if (max_clr) begin
          max_q[g]    <= `MSD_MAX_RST;
          max_seen[g] <= 1'b0;
        end else if (take_max) begin
          max_q[g]    <= x;
          max_seen[g] <= 1'b1;
        end
      end

      // Voltage keeps no peak; its peak word is unmapped
      msd_averager #(
        .DEPTH    (DEPTH),
        .HAS_PEAK (g != 1)
      ) u_avg (
        .pclk         (pclk),
        .presetn      (presetn),
        .clear        (gclr),
        .sample_valid (meas.valid),
        .sample       (x),
        .start_edge   (pin_rise[g]),
        .cfg          (gcfg),
        .avg          (avg_q[g]),
        .peak         (peak_q[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// ---- shared/msd_cfg.svh ----
`ifndef MSD_CFG_SVH
`define MSD_CFG_SVH

// Register byte offsets on the APB bus
`define MSD_OFF_CTRL        12'h000
`define MSD_OFF_CMD         12'h004
`define MSD_OFF_STATUS      12'h008
`define MSD_OFF_DUR         12'h010
`define MSD_OFF_AVG         12'h020
`define MSD_OFF_PEAK        12'h030
`define MSD_OFF_MIN         12'h040
`define MSD_OFF_MAX         12'h050
`define MSD_BLOCK_MASK      12'hff0

// Control register layout: one 4-bit field per group, then min/max enables
`define MSD_CTRL_GRP_STRIDE 4
`define MSD_CTRL_WIN        0
`define MSD_CTRL_START      1
`define MSD_CTRL_CLREN      2
`define MSD_CTRL_MINCLR_EN  12
`define MSD_CTRL_MAXCLR_EN  13
`define MSD_CTRL_MASK       32'h0000_3777

// Command register layout (write-one pulses)
`define MSD_CMD_GRP_CLR     0
`define MSD_CMD_MIN_CLR     4
`define MSD_CMD_MAX_CLR     5

// Status register layout
`define MSD_STAT_PINS       0
`define MSD_STAT_MIN_SEEN   8
`define MSD_STAT_MAX_SEEN   11

// Reset values
`define MSD_CTRL_RST        32'h0000_0000
`define MSD_DUR_RST         16'h0010
`define MSD_MIN_RST         16'hffff
`define MSD_MAX_RST         16'h0000

// Timing: synchroniser depth for pins
`define MSD_SYNC_STAGES     3

`endif

// ---- shared/msd_pkg.sv ----
`default_nettype none
package msd_pkg;

  typedef logic [15:0] msd_value_t;

  typedef enum logic {
    MSD_WIN_SLIDING = 1'b0,
    MSD_WIN_FIXED   = 1'b1
  } msd_win_t;

  typedef enum logic {
    MSD_START_DURATION = 1'b0,
    MSD_START_EDGE     = 1'b1
  } msd_start_t;

  typedef struct packed {
    msd_win_t    win;
    msd_start_t  start;
    logic [15:0] dur;
  } msd_grp_cfg_t;

  // Index 0 current, 1 voltage, 2 power
  typedef struct packed {
    logic                   valid;
    msd_value_t [2:0]       val;
  } msd_meas_t;

endpackage
`default_nettype wire

// ---- design/msd_averager.sv ----
`timescale 1ns/1ps
`default_nettype none
module msd_averager #(
  parameter int DEPTH    = 64,
  parameter bit HAS_PEAK = 1'b1
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  clear,
  input  wire logic                  sample_valid,
  input  wire msd_pkg::msd_value_t   sample,
  input  wire logic                  start_edge,
  input  wire msd_pkg::msd_grp_cfg_t cfg,
  output var  msd_pkg::msd_value_t   avg,
  output var  msd_pkg::msd_value_t   peak
);
  import msd_pkg::*;

  localparam int PW = $clog2(DEPTH) + 1;
  localparam int SW = 16 + PW;

  logic [PW-1:0] last_len;
  logic [PW-1:0] seg;
  logic [PW-1:0] cnt;
  logic [PW-1:0] fill;
  logic [PW-2:0] wptr;
  logic [SW-1:0] sum;
  msd_value_t    ring [DEPTH];

  wire           edge_mode = cfg.start == MSD_START_EDGE;
  wire           fixed     = cfg.win == MSD_WIN_FIXED;
  // Period lengths are counted in samples and capped at DEPTH
  wire [PW-1:0]  dur_len   = (cfg.dur == 16'h0000) ? PW'(1) :
                             (cfg.dur >= 16'(DEPTH)) ? PW'(DEPTH) : cfg.dur[PW-1:0];
  wire [PW-1:0]  len       = edge_mode ? last_len : dur_len;
  wire           full      = fill >= len;
  wire [SW-1:0]  oldest    = full ? SW'(ring[wptr]) : '0;
  wire [SW-1:0]  next_sum_slide = sum + SW'(sample) - oldest;
  wire [PW-1:0]  next_fill = full ? fill : fill + 1'b1;
  wire [SW-1:0]  next_sum_fix = sum + SW'(sample);
  wire [PW-1:0]  next_cnt  = cnt + 1'b1;
  wire           cap       = cnt == PW'(DEPTH);
  wire           dur_end   = !edge_mode && (next_cnt >= len);
  wire           seg_restart = edge_mode && start_edge;
  wire [PW-1:0]  seg_len   = (seg == '0) ? PW'(1) : seg;
  wire           slide_reset = seg_restart && (seg_len != last_len);
  wire [PW-1:0]  next_wptr_w = {1'b0, wptr} + 1'b1;
  wire [PW-2:0]  next_wptr = (next_wptr_w >= len) ? '0 : next_wptr_w[PW-2:0];

  wire [SW-1:0]  q_slide   = next_sum_slide / SW'(next_fill);
  wire [SW-1:0]  q_fix     = next_sum_fix / SW'(next_cnt);
  wire [SW-1:0]  q_edge    = sum / SW'((cnt == '0) ? PW'(1) : cnt);

  wire           upd_edge  = fixed && seg_restart && (cnt != '0);
  wire           upd_fix   = fixed && sample_valid && dur_end;
  wire           upd_slide = !fixed && sample_valid && !slide_reset;
  wire           upd       = upd_edge || upd_fix || upd_slide;
  wire msd_value_t next_avg = upd_edge ? q_edge[15:0] : fixed ? q_fix[15:0] : q_slide[15:0];
  wire           ring_we   = !clear && upd_slide;

  // Sample history has no reset; fill tracks which entries are live
  always_ff @(posedge pclk) begin
    if (ring_we) begin
      ring[wptr] <= sample;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg      <= '0;
      peak     <= '0;
      sum      <= '0;
      cnt      <= '0;
      fill     <= '0;
      wptr     <= '0;
      seg      <= '0;
      last_len <= PW'(1);
    end else if (clear) begin
      avg      <= '0;
      peak     <= '0;
      sum      <= '0;
      cnt      <= '0;
      fill     <= '0;
      wptr     <= '0;
      seg      <= '0;
      last_len <= PW'(1);
    end else begin
      if (upd) begin
        avg <= next_avg;
      end
      if (HAS_PEAK && upd && (next_avg > peak)) begin
        peak <= next_avg;
      end
      if (seg_restart) begin
        seg      <= '0;
        last_len <= seg_len;
      end else if (sample_valid && (seg != PW'(DEPTH))) begin
        seg <= seg + 1'b1;
      end
      if (fixed) begin
        // Sample arriving on the period boundary closes the old period
        if (seg_restart || (sample_valid && dur_end)) begin
          sum <= '0;
          cnt <= '0;
        end else if (sample_valid && !cap) begin
          sum <= next_sum_fix;
          cnt <= next_cnt;
        end
      end else begin
        if (slide_reset) begin
          sum  <= '0;
          fill <= '0;
          wptr <= '0;
        end else if (sample_valid) begin
          sum  <= next_sum_slide;
          fill <= next_fill;
          wptr <= next_wptr;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- sim/msd_statistics_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msd_cfg.svh"
module msd_statistics_properties #(
  parameter int DEPTH = 64
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire msd_pkg::msd_meas_t meas
);
  import msd_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic [11:0] a = {paddr[11:2], 2'b00};
  wire logic        setup = psel && !penable;
  // Voltage keeps no peak, so its slot is left out on purpose
  wire logic        hit = a inside {12'h000, 12'h004, 12'h008, 12'h010, 12'h014, 12'h018, 12'h020,
    12'h024, 12'h028, 12'h030, 12'h038, 12'h040, 12'h044, 12'h048, 12'h050, 12'h054, 12'h058};
  sequence s_wr(logic [11:0] at, logic [31:0] d);
    psel && penable && pwrite && a == at && pwdata == d;
  endsequence
  sequence s_rd(logic [11:0] at);
    setup && !pwrite && a == at && !meas.valid;
  endsequence
  property p_clr(logic [31:0] bits, logic [11:0] at, logic [31:0] val);
    s_wr(`MSD_OFF_CMD, bits) ##1 s_rd(at) |=> prdata == val;
  endproperty
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (setup && !hit |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (setup && hit |=> !pslverr)
    else $error("mapped access refused");
  a_rdata_stands: assert property (!$past(setup) |-> $stable(prdata) && $stable(pslverr))
    else $error("read data moved outside setup");
  a_cmd_reads0: assert property (s_rd(`MSD_OFF_CMD) |=> prdata == 32'h0)
    else $error("command register read not zero");
  a_cfg_restart: assert property (psel && penable && pwrite && a == `MSD_OFF_CTRL
    ##1 s_rd(`MSD_OFF_MIN) |=> prdata == 32'h0000ffff) else $error("min kept over config");
  a_min_cmd: assert property (p_clr(32'h10, 12'h044, 32'h0000ffff))
    else $error("min clear failed");
  a_max_cmd: assert property (p_clr(32'h20, `MSD_OFF_MAX, 32'h0))
    else $error("max clear failed");
  a_grp_cmd: assert property (p_clr(32'h1, `MSD_OFF_AVG, 32'h0))
    else $error("group clear failed");
  a_peak_cmd: assert property (p_clr(32'h4, 12'h038, 32'h0))
    else $error("peak clear failed");
endmodule
`default_nettype wire

// ---- sim/msd_field_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module msd_field_model (
  input  wire logic                      pclk,
  input  wire logic                      go,
  input  wire msd_pkg::msd_value_t [2:0] v,
  input  wire logic [7:0]                pins_req,
  output var  msd_pkg::msd_meas_t        meas,
  output var  logic [7:0]                pins
);
  import msd_pkg::*;
  // Idle value lines carry the inverse so a stale sample cannot pass for data
  always_ff @(posedge pclk) begin
    meas.valid <= go;
    meas.val   <= go ? v : ~v;
    pins       <= pins_req;
  end
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "msd_cfg.svh"
module testbench;
  import msd_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [11:0]      paddr = 12'h000;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             go = 1'b0;
  msd_value_t [2:0] v = '0;
  logic [7:0]       pins_req = 8'h00;
  logic [7:0]       pins;
  msd_meas_t        meas;
  logic [15:0]      seed = 16'h63f6;
  int               n_fail = 0;
  int               compares = 0;
  int               mn[3], mx[3], av[3], pk[3], dur[3];
  int               q[3][$];
  bit               fx[3];

  always #2.5 pclk = ~pclk;

  msd_statistics #(.DEPTH(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas), .current_avg_start_source(pins[0]),
    .voltage_avg_start_source(pins[1]), .power_avg_start_source(pins[2]),
    .current_avg_clear_source(pins[3]), .voltage_avg_clear_source(pins[4]),
    .power_avg_clear_source(pins[5]), .minimum_clear_source(pins[6]),
    .maximum_clear_source(pins[7]));
  msd_field_model FM (.pclk(pclk), .go(go), .v(v), .pins_req(pins_req), .meas(meas),
    .pins(pins));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Chained transfers keep psel high so the next setup follows at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input bit chain, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    if (!chain) begin
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ee = 1'b0);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, 1'b0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ee});
  endtask

  // Always chained: every write must be followed by another transfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, 1'b1, r, e);
  endtask

  task automatic clr_grp(input int g);
    av[g] = 0;
    pk[g] = 0;
    q[g].delete();
  endtask

  task automatic clr_mm(input bit lo, input bit hi);
    for (int g = 0; g < 3; g++) begin
      if (lo) mn[g] = 65535;
      if (hi) mx[g] = 0;
    end
  endtask

  task automatic avg_upd(input int g);
    int s = 0;
    foreach (q[g][i]) s += q[g][i];
    av[g] = s / q[g].size();
    if (av[g] > pk[g] && g != 1) pk[g] = av[g];
  endtask

  task automatic smp();
    for (int g = 0; g < 3; g++) begin
      seed = lfsr(seed);
      v[g] <= seed;
      if (seed < mn[g]) mn[g] = seed;
      if (seed > mx[g]) mx[g] = seed;
      q[g].push_back(seed);
      if (!fx[g] && q[g].size() > dur[g]) void'(q[g].pop_front());
      if (!fx[g] || q[g].size() == dur[g]) avg_upd(g);
      if (fx[g] && q[g].size() == dur[g]) q[g].delete();
    end
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cfg(input logic [31:0] c, input int d0, input int d1, input int d2);
    int d[3] = '{d0, d1, d2};
    for (int g = 0; g < 3; g++) wr(12'(`MSD_OFF_DUR + 4 * g), 32'(d[g]));
    wr(`MSD_OFF_CTRL, c);
    rd(`MSD_OFF_MIN, 32'h0000ffff);
    rd(`MSD_OFF_CTRL, c);
    for (int g = 0; g < 3; g++) begin
      dur[g] = d[g];
      fx[g] = c[4 * g];
      clr_grp(g);
    end
    clr_mm(1'b1, 1'b1);
  endtask

  task automatic chk_all();
    for (int g = 0; g < 3; g++) begin
      rd(12'(`MSD_OFF_MIN + 4 * g), 32'(mn[g]));
      rd(12'(`MSD_OFF_MAX + 4 * g), 32'(mx[g]));
      rd(12'(`MSD_OFF_AVG + 4 * g), 32'(av[g]));
      if (g != 1) rd(12'(`MSD_OFF_PEAK + 4 * g), 32'(pk[g]));
    end
  endtask

  task automatic pulse(input int i);
    pins_req[i] <= 1'b1;
    repeat (8) @(posedge pclk);
    pins_req[i] <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`MSD_OFF_CTRL, `MSD_CTRL_RST);
    for (int g = 0; g < 3; g++) rd(12'(`MSD_OFF_DUR + 4 * g), {16'h0, `MSD_DUR_RST});
    rd(12'h034, 32'h0, 1'b1);
    rd(`MSD_OFF_CMD, 32'h0);
    cfg(32'h111, 2, 3, 1);
    repeat (6) smp();
    chk_all();
    cfg(32'h0, 3, 2, 4);
    for (int k = 0; k < 5; k++) begin
      smp();
      chk_all();
    end
    wr(`MSD_OFF_CMD, 32'h1);
    rd(`MSD_OFF_AVG, 32'h0);
    wr(`MSD_OFF_CMD, 32'h4);
    rd(12'h038, 32'h0);
    wr(`MSD_OFF_CMD, 32'h10);
    rd(12'h044, 32'h0000ffff);
    clr_grp(0);
    clr_grp(2);
    clr_mm(1'b1, 1'b0);
    chk_all();
    wr(`MSD_OFF_CMD, 32'h20);
    rd(`MSD_OFF_MAX, 32'h0);
    clr_mm(1'b0, 1'b1);
    cfg(32'h3400, 2, 2, 2);
    repeat (3) smp();
    pulse(5);
    clr_grp(2);
    chk_all();
    pins_req[6] <= 1'b1;
    repeat (8) @(posedge pclk);
    clr_mm(1'b1, 1'b0);
    smp();
    repeat (8) @(posedge pclk);
    chk_all();
    pins_req[6] <= 1'b0;
    pulse(7);
    clr_mm(1'b0, 1'b1);
    chk_all();
    cfg(32'h3, 2, 2, 2);
    dur[0] = 1000;
    pulse(0);
    repeat (3) smp();
    pulse(0);
    avg_upd(0);
    q[0].delete();
    chk_all();
    // A restart in mid-run must bring every tracked value back to its reset state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int g = 0; g < 3; g++) begin
      clr_grp(g);
    end
    clr_mm(1'b1, 1'b1);
    chk_all();
    rd(`MSD_OFF_CTRL, `MSD_CTRL_RST);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    wrap_up();
  end
endmodule

bind msd_statistics msd_statistics_properties #(.DEPTH(DEPTH)) u_props (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas));
`default_nettype wire
